/* common/dusp_pkg.sv */
// What this block does
// - break, framing and parity flags are stored with each received character.
// - status read gives head-character flags in 7:5, then overrun, tx empty, tx ready, full, ready.
// - the reset error command clears the per-character flags shown in status.
// - in character mode a character's flags leave with it when the host pops it.
// - in block mode flags accumulate until error reset or receiver reset.
// - pin function bits 7..4 route tx ready B, tx ready A, rx int B, rx int A.
// - pin 3 field picks latch, counter output, B tx 1x clock or B rx 1x clock.
// - pin 2 field picks latch, A tx 16x clock, A tx 1x clock or A rx 1x clock.
// - each output latch bit drives its pin inverted, 1 means pin low.
// - auxiliary control bit 7 picks the first or second fixed baud table.
// - auxiliary bits 3..0 let input changes set interrupt status bit 7.
// - interrupt status bits 6 and 2 flag break changes on channels B and A.
// - interrupt status bit 3 flags the counter/timer terminal condition.
// - status bits 5,1 mirror rx ready/full, 4,0 tx ready; mask 0 turns off.
// - rx ready/full asserts when fill reaches 1, 3, 6 or 8 per level bits.
package dusp_pkg;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [3:0] OFS_LINE_STAT_A = 4'h1;
	localparam logic [3:0] OFS_ISR_CLEAR   = 4'h2;
	localparam logic [3:0] OFS_RX_DATA_A   = 4'h3;
	localparam logic [3:0] OFS_AUX_IPC     = 4'h4;
	localparam logic [3:0] OFS_ISR_IMR     = 4'h5;
	localparam logic [3:0] OFS_LINE_STAT_B = 4'h9;
	localparam logic [3:0] OFS_RX_DATA_B   = 4'hb;
	localparam logic [3:0] OFS_PIN_FUNC    = 4'hd;
	localparam logic [3:0] OFS_BITS_SET    = 4'he;
	localparam logic [3:0] OFS_BITS_CLEAR  = 4'hf;
	// ---------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------
	localparam int         ACR_BAUD_SET_BIT = 7;
	localparam int         ISR_PORT_CHG_BIT = 7;
	localparam int         ISR_BRK_B_BIT    = 6;
	localparam int         ISR_CT_BIT       = 3;
	localparam int         ISR_BRK_A_BIT    = 2;
	localparam logic [7:0] ISR_STICKY_MASK  = 8'h00_cc;
	localparam logic [7:0] RST_AUX          = 8'h00_00;
	localparam logic [7:0] RST_MASK         = 8'h00_00;
	localparam logic [7:0] RST_PIN_FUNC     = 8'h00_00;
	localparam logic [7:0] RST_LATCH        = 8'h00_00;
	// ---------------------------------------------------------------
	// receive fill thresholds and pin 3/2 selections
	// ---------------------------------------------------------------
	localparam int         RX_FIFO_DEPTH = 8;
	localparam logic [3:0] RX_THR_0      = 4'h1;
	localparam logic [3:0] RX_THR_1      = 4'h3;
	localparam logic [3:0] RX_THR_2      = 4'h6;
	localparam logic [3:0] RX_THR_3      = 4'h8;
	localparam logic [1:0] PSEL_LATCH    = 2'h0;
	localparam logic [1:0] PSEL_ONE      = 2'h1;
	localparam logic [1:0] PSEL_TWO      = 2'h2;
endpackage : dusp_pkg

/* verilog/dusp_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module dusp_regs
	import dusp_pkg::*;
#(
	parameter int DEPTH = RX_FIFO_DEPTH
)
(
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	input  wire logic             clk_en,
	input  wire logic [3:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [7:0]       reg_rdata,
	input  wire logic [1:0]       rx_push,
	input  wire logic [1:0][7:0]  rx_char,
	input  wire logic [1:0][2:0]  rx_flags,
	input  wire logic [1:0]       block_err_mode,
	input  wire logic [1:0][1:0]  rx_level,
	input  wire logic [1:0]       err_reset,
	input  wire logic [1:0]       rx_reset,
	input  wire logic [1:0]       transmitter_empty,
	input  wire logic [1:0]       transmitter_ready,
	input  wire logic [1:0]       break_change,
	input  wire logic             ct_terminal,
	input  wire logic             ct_output,
	input  wire logic [3:0]       in_pin,
	input  wire logic             chan_a_transmit_clock_16x,
	input  wire logic             chan_a_transmit_clock,
	input  wire logic             chan_a_receive_clock,
	input  wire logic             chan_b_transmit_clock,
	input  wire logic             chan_b_receive_clock,
	output logic      [7:0]       out_pin,
	output logic                  baud_table_sel,
	output logic                  irq
);
	// stored entry is three flags over eight data bits; syncs cover nine pins
	localparam int FW    = 11;
	localparam int CW    = $clog2(DEPTH + 1);
	localparam int PW    = $clog2(DEPTH);
	localparam int NSYNC = 9;

	// every flop of the block but the two reset-release flops lives in this one record, registered in one place
	typedef struct packed {
		logic [7:0]                      rdata;
		logic [7:0]                      aux;
		logic [7:0]                      mask;
		logic [7:0]                      pin_func;
		logic [7:0]                      latch;
		logic [7:0]                      sticky;
		logic [7:0]                      pins;
		logic                            irq;
		logic [NSYNC-1:0]                sy_m;
		logic [NSYNC-1:0]                sy_s;
		logic [3:0]                      ip_q;
		logic [3:0]                      ip_delta;
		logic [1:0]                      warm;
		logic [1:0][DEPTH-1:0][FW-1:0]   mem;
		logic [1:0][PW-1:0]              wp;
		logic [1:0][PW-1:0]              rp;
		logic [1:0][CW-1:0]              cnt;
		logic [1:0]                      ovr;
		logic [1:0][2:0]                 acc;
	} dusp_state_t;

	dusp_state_t s;
	dusp_state_t n;
	logic        rst_m;
	logic        rst_n_s;

	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	// assertion is asynchronous, release passes two flops
	// so every state flop leaves reset on the same clean edge
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_m   <= 1'b0;
			rst_n_s <= 1'b0;
		end
		else
		begin
			rst_m   <= 1'b1;
			rst_n_s <= rst_m;
		end
	end

	// ---------------------------------------------------------------
	// per-channel status views
	// ---------------------------------------------------------------
	logic [1:0][FW-1:0] head;
	logic [1:0][2:0]    flags;
	logic [1:0]         has_char;
	logic [1:0]         fifo_full;
	logic [1:0]         rx_int;
	logic [1:0][7:0]    line_stat;
	logic [1:0][3:0]    thr;

	// both channels are built alike; index 0 is channel a, 1 is channel b
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_chan
			assign head[ch]      = s.mem[ch][s.rp[ch]];
			assign has_char[ch]  = (s.cnt[ch] != '0);
			assign fifo_full[ch] = (s.cnt[ch] == CW'(DEPTH));
			assign flags[ch] = (has_char[ch] ? head[ch][FW-1:8] : 3'b000)
				| (block_err_mode[ch] ? s.acc[ch] : 3'b000);
			assign thr[ch] = (rx_level[ch] == 2'd0) ? RX_THR_0 :
				(rx_level[ch] == 2'd1) ? RX_THR_1 :
				(rx_level[ch] == 2'd2) ? RX_THR_2 : RX_THR_3;
			assign rx_int[ch] = (s.cnt[ch] >= CW'(thr[ch]));
			assign line_stat[ch] = {flags[ch], s.ovr[ch], transmitter_empty[ch],
				transmitter_ready[ch], fifo_full[ch], has_char[ch]};
		end
	endgenerate

	// ---------------------------------------------------------------
	// interrupt status word and pin selection
	// ---------------------------------------------------------------
	logic [7:0] isr_w;
	logic [7:0] pin_sel;
	logic [3:0] ip_now;

	// event bits latch until cleared; ready bits follow their live levels
	// live mirrors beside sticky bits
	assign isr_w = (s.sticky & ISR_STICKY_MASK)
		| {2'b00, rx_int[1], transmitter_ready[1], 2'b00, rx_int[0], transmitter_ready[0]};
	assign ip_now = s.sy_s[3:0];

	// clocks reach the pins through the synchronisers, so they lag by
	// three cycles; fine for baud clocks well below the reference rate
	always_comb
	begin
		// anything not routed below shows its latch bit
		pin_sel = s.latch;
		if (s.pin_func[7])
			pin_sel[7] = transmitter_ready[1];
		if (s.pin_func[6])
			pin_sel[6] = transmitter_ready[0];
		if (s.pin_func[5])
			pin_sel[5] = rx_int[1];
		if (s.pin_func[4])
			pin_sel[4] = rx_int[0];
		case (s.pin_func[3:2])
			PSEL_LATCH: pin_sel[3] = s.latch[3];
			PSEL_ONE:   pin_sel[3] = ct_output;
			PSEL_TWO:   pin_sel[3] = s.sy_s[7];
			default:    pin_sel[3] = s.sy_s[8];
		endcase
		case (s.pin_func[1:0])
			PSEL_LATCH: pin_sel[2] = s.latch[2];
			PSEL_ONE:   pin_sel[2] = s.sy_s[4];
			PSEL_TWO:   pin_sel[2] = s.sy_s[5];
			default:    pin_sel[2] = s.sy_s[6];
		endcase
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	// a character leaves its fifo only through pop or a receiver reset; an empty fifo pops nothing
	logic [1:0] pop;
	logic [3:0] ip_change;
	logic       wr_hit;
	logic       rd_hit;
	int         i;

	always_comb
	begin
		n         = s;
		pop       = 2'b00;
		ip_change = 4'h0;
		wr_hit    = reg_wr;
		rd_hit    = reg_rd;
		n.rdata   = 8'h00_00;

		// pins pass two flops before anything looks at them
		n.sy_m = {chan_b_receive_clock, chan_b_transmit_clock, chan_a_receive_clock,
			chan_a_transmit_clock, chan_a_transmit_clock_16x, in_pin};
		n.sy_s = s.sy_m;
		n.ip_q = ip_now;
		// the synchroniser and the level copy come out of reset at zero, so the
		// first comparisons would see a false change on an input idling high;
		// detection waits until the warm-up count has run out
		if (s.warm != '1)
			n.warm = s.warm + 2'h1;
		if (s.warm == '1)
			ip_change = ip_now ^ s.ip_q;

		// register reads: data stands in the next cycle only
		if (rd_hit)
		begin
			case (reg_addr)
				OFS_LINE_STAT_A: n.rdata = line_stat[0];
				OFS_LINE_STAT_B: n.rdata = line_stat[1];
				// reading an empty fifo returns zero and leaves the pointers alone
				OFS_RX_DATA_A:
				begin
					n.rdata = has_char[0] ? head[0][7:0] : 8'h00_00;
					pop[0]  = has_char[0];
				end
				OFS_RX_DATA_B:
				begin
					n.rdata = has_char[1] ? head[1][7:0] : 8'h00_00;
					pop[1]  = has_char[1];
				end
				OFS_AUX_IPC:
				begin
					n.rdata    = {s.ip_delta, ip_now};
					n.ip_delta = 4'h0;
				end
				OFS_ISR_IMR: n.rdata = isr_w;
				default:     n.rdata = 8'h00_00;
			endcase
		end

		// register writes
		// one strobe at a time, so a read never meets a write in this cycle
		if (wr_hit)
		begin
			case (reg_addr)
				// baud table select lives in aux bit 7
				OFS_AUX_IPC:  n.aux      = reg_wdata;
				OFS_ISR_IMR:  n.mask     = reg_wdata;
				OFS_PIN_FUNC: n.pin_func = reg_wdata;
				OFS_BITS_SET:   n.latch = s.latch | reg_wdata;
				OFS_BITS_CLEAR: n.latch = s.latch & ~reg_wdata;
				OFS_ISR_CLEAR:  n.sticky = s.sticky & ~(reg_wdata & ISR_STICKY_MASK);
				// read-only and unused places ignore writes
				default:        n.latch = s.latch;
			endcase
		end

		// input changes: set after the read clear so an edge is never lost
		n.ip_delta = n.ip_delta | ip_change;
		if (|(ip_change & s.aux[3:0]))
			n.sticky[ISR_PORT_CHG_BIT] = 1'b1;
		if (break_change[1])
			n.sticky[ISR_BRK_B_BIT] = 1'b1;
		if (break_change[0])
			n.sticky[ISR_BRK_A_BIT] = 1'b1;
		if (ct_terminal)
			n.sticky[ISR_CT_BIT] = 1'b1;

		// receive FIFOs
		// a receiver reset outranks every other request of its channel
		for (i = 0; i < 2; i++)
		begin
			if (rx_reset[i])
			begin
				n.wp[i]  = '0;
				n.rp[i]  = '0;
				n.cnt[i] = '0;
				n.acc[i] = 3'b000;
				n.ovr[i] = 1'b0;
			end
			else
			begin
				if (err_reset[i])
				begin
					n.acc[i] = 3'b000;
					n.ovr[i] = 1'b0;
					n.mem[i][s.rp[i]][FW-1:8] = 3'b000;
				end
				else if (has_char[i])
					n.acc[i] = s.acc[i] | head[i][FW-1:8];
				if (pop[i])
				begin
					n.rp[i] = PW'(s.rp[i] + 1'b1);
				end
				// a full fifo still takes a push when a pop frees a slot this cycle
				if (rx_push[i] && (!fifo_full[i] || pop[i]))
				begin
					n.mem[i][s.wp[i]] = {rx_flags[i], rx_char[i]};
					n.wp[i] = PW'(s.wp[i] + 1'b1);
				end
				else if (rx_push[i])
					n.ovr[i] = 1'b1;
				// the count moves only when exactly one of push and pop happens
				if ((rx_push[i] && (!fifo_full[i] || pop[i])) && !pop[i])
					n.cnt[i] = CW'(s.cnt[i] + 1'b1);
				else if (pop[i] && !(rx_push[i]))
					n.cnt[i] = CW'(s.cnt[i] - 1'b1);
			end
		end

		n.pins = ~pin_sel;
		// registered, so irq trails its source by one cycle
		// mask gates each source
		n.irq  = |(isr_w & s.mask);
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			s          <= '0;
			s.aux      <= RST_AUX;
			s.mask     <= RST_MASK;
			s.pin_func <= RST_PIN_FUNC;
			s.latch    <= RST_LATCH;
			s.pins     <= ~RST_LATCH;
		end
		else if (clk_en)
		begin
			s <= n;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// outputs straight from state
	assign reg_rdata      = s.rdata;
	assign out_pin        = s.pins;
	assign baud_table_sel = s.aux[ACR_BAUD_SET_BIT];
	assign irq            = s.irq;
endmodule : dusp_regs
`default_nettype wire

/* dv/dusp_regs_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module dusp_regs_sva
	import dusp_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       nrst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] transmitter_ready,
	input wire logic       ct_terminal,
	input wire logic [7:0] out_pin,
	input wire logic       baud_table_sel,
	input wire logic       irq
);
	logic [7:0] mask_r, lat_r, pf_r;
	// shadows of write-only registers, since the checker cannot read them back
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			{mask_r, lat_r, pf_r} <= '0;
		else if (reg_wr)
		begin
			if (reg_addr == OFS_ISR_IMR) mask_r <= reg_wdata;
			if (reg_addr == OFS_PIN_FUNC) pf_r <= reg_wdata;
			if (reg_addr == OFS_BITS_SET) lat_r <= lat_r | reg_wdata;
			if (reg_addr == OFS_BITS_CLEAR) lat_r <= lat_r & ~reg_wdata;
		end
	end
	default clocking dcb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// read data only in the cycle after a read
	a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside their cycle");
	a_baud_follow: assert property (reg_wr && reg_addr == OFS_AUX_IPC
		|=> baud_table_sel == $past(reg_wdata[ACR_BAUD_SET_BIT])) else $error("baud table select");
	a_baud_hold: assert property (!(reg_wr && reg_addr == OFS_AUX_IPC)
		|=> $stable(baud_table_sel)) else $error("baud table select moved");
	// latch drives pins inverted while no function is routed
	a_pin_latch: assert property (pf_r == 8'h00 && $past(pf_r) == 8'h00
		|-> out_pin == ~$past(lat_r)) else $error("latch pin level");
	a_pin_ready: assert property (pf_r[7:6] == 2'b11 && $past(pf_r[7:6]) == 2'b11
		|-> out_pin[7:6] == ~$past(transmitter_ready)) else $error("ready pin level");
	a_irq_masked: assert property (mask_r == 8'h00 && $past(mask_r) == 8'h00 |-> !irq)
		else $error("interrupt with all sources masked");
	a_ct_irq: assert property (ct_terminal && mask_r[ISR_CT_BIT] && !reg_wr
		|-> ##[1:2] irq) else $error("counter event lost");
	a_tx_irq: assert property (transmitter_ready[0] && mask_r[0] && !reg_wr
		|-> ##[1:2] irq) else $error("tx ready interrupt missing");
endmodule : dusp_regs_sva
bind dusp_regs dusp_regs_sva dusp_regs_sva_inst (.ref_clk, .nrst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .transmitter_ready, .ct_terminal, .out_pin,
	.baud_table_sel, .irq);
`default_nettype wire

/* dv/dusp_host.sv */
`timescale 1ns/10ps
`default_nettype none
module dusp_host
(
	input  wire logic       ref_clk,
	output logic      [3:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
	// set and clear are single strobes
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// data are taken inside their only valid cycle
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		// the data stand until the next edge; take them there, before they clear
		@(posedge ref_clk);
		v = reg_rdata;
	endtask : rd
endmodule : dusp_host
`default_nettype wire

/* dv/dusp_regs_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module dusp_regs_tb_top
	import dusp_pkg::*;
;
	logic            ref_clk = 1'b0, nrst = 1'b0, reg_wr, reg_rd, baud_table_sel, irq;
	logic [3:0]      reg_addr, in_pin = '0;
	logic [7:0]      reg_wdata, reg_rdata, out_pin, d;
	logic [1:0]      rx_push = '0, blk = '0, er = '0, te = '0, tr = '0, rr = '0;
	logic [1:0][7:0] rx_char = '0;
	logic [1:0][2:0] rx_flags = '0;
	logic [1:0][1:0] lvl = '0;
	logic [2:0]      ev = '0;
	logic [5:0]      src = '0;
	logic [3:0]      thr [4] = '{RX_THR_0, RX_THR_1, RX_THR_2, RX_THR_3};
	logic [7:0]      ebit [3] = '{8'h40, 8'h08, 8'h04};
	int              failures = 0, checks_done = 0, n;
	always #5 ref_clk = ~ref_clk;
	dusp_host dusp_host_inst (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	// channel a carries most receive traffic, channel b a single character
	dusp_regs dusp_regs_inst (.ref_clk, .nrst, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .rx_push, .rx_char, .rx_flags, .block_err_mode(blk),
		.rx_level(lvl), .err_reset(er), .rx_reset(rr), .transmitter_empty(te),
		.transmitter_ready(tr), .break_change({ev[0], ev[2]}), .ct_terminal(ev[1]),
		.ct_output(src[3]), .in_pin, .chan_a_transmit_clock_16x(src[0]),
		.chan_a_transmit_clock(src[1]), .chan_a_receive_clock(src[2]),
		.chan_b_transmit_clock(src[4]), .chan_b_receive_clock(src[5]), .out_pin,
		.baud_table_sel, .irq);
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : cyc
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rdm(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
		dusp_host_inst.rd(a, d);
		chk(d & m, exp);
	endtask : rdm
	task automatic push(input logic [7:0] c, input logic [2:0] f);
		@(posedge ref_clk);
		rx_push[0] <= 1'b1;
		rx_char[0] <= c;
		rx_flags[0] <= f;
		@(posedge ref_clk);
		rx_push[0] <= 1'b0;
	endtask : push
	task automatic err_pulse;
		@(posedge ref_clk);
		er[0] <= 1'b1;
		@(posedge ref_clk);
		er[0] <= 1'b0;
	endtask : err_pulse
	task automatic conclude;
		if (failures == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	// watchdog: the sequence needs well under two thousand cycles
	initial
	begin
		#100000;
		failures++;
		conclude();
	end
	// main sequence, reset levels and a channel b character before channel a status flags
	initial
	begin
		cyc(10);
		// levels held during reset
		chk(out_pin, 8'hff);
		chk({7'h0, baud_table_sel}, 8'h00);
		chk({7'h0, irq}, 8'h00);
		nrst <= 1'b1;
		cyc(3);
		te <= 2'b01;
		// channel b: one character shows in its status and interrupt bit
		@(posedge ref_clk);
		rx_push[1] <= 1'b1;
		rx_char[1] <= 8'h5b;
		rx_flags[1] <= 3'b010;
		@(posedge ref_clk);
		rx_push[1] <= 1'b0;
		rdm(OFS_LINE_STAT_B, 8'hff, 8'h41);
		rdm(OFS_ISR_IMR, 8'h20, 8'h20);
		rdm(OFS_RX_DATA_B, 8'hff, 8'h5b);
		rdm(OFS_LINE_STAT_B, 8'hff, 8'h00);
		push(8'h3c, 3'b101);
		rdm(OFS_LINE_STAT_A, 8'hff, 8'ha9);
		rdm(OFS_RX_DATA_A, 8'hff, 8'h3c);
		rdm(OFS_LINE_STAT_A, 8'hff, 8'h08);
		push(8'h11, 3'b111);
		err_pulse();
		rdm(OFS_LINE_STAT_A, 8'hff, 8'h09);
		rdm(OFS_RX_DATA_A, 8'hff, 8'h11);
		blk <= 2'b01;
		push(8'h22, 3'b010);
		push(8'h33, 3'b000);
		rdm(OFS_RX_DATA_A, 8'hff, 8'h22);
		rdm(OFS_LINE_STAT_A, 8'hff, 8'h49);
		err_pulse();
		rdm(OFS_LINE_STAT_A, 8'hff, 8'h09);
		rdm(OFS_RX_DATA_A, 8'hff, 8'h33);
		// block flags outlive their character until a receiver reset
		push(8'h44, 3'b100);
		rdm(OFS_RX_DATA_A, 8'hff, 8'h44);
		rdm(OFS_LINE_STAT_A, 8'hff, 8'h88);
		rr <= 2'b01;
		@(posedge ref_clk);
		rr <= 2'b00;
		rdm(OFS_LINE_STAT_A, 8'hff, 8'h08);
		blk <= 2'b00;
		// fill levels, full and overrun only on the deepest setting
		for (int l = 0; l < 4; l++)
		begin
			lvl[0] <= l[1:0];
			n = int'(thr[l]);
			for (int i = 1; i < n; i++) push(i[7:0], 3'b000);
			rdm(OFS_ISR_IMR, 8'h02, 8'h00);
			push(8'h55, 3'b000);
			rdm(OFS_ISR_IMR, 8'h02, 8'h02);
			if (l == 3)
			begin
				rdm(OFS_LINE_STAT_A, 8'h12, 8'h02);
				push(8'h66, 3'b000);
				rdm(OFS_LINE_STAT_A, 8'h12, 8'h12);
				err_pulse();
			end
			repeat (n) dusp_host_inst.rd(OFS_RX_DATA_A, d);
		end
		lvl[0] <= 2'b00;
		dusp_host_inst.wr(OFS_BITS_SET, 8'ha5);
		cyc(2);
		chk(out_pin, 8'h5a);
		dusp_host_inst.wr(OFS_BITS_CLEAR, 8'h81);
		cyc(2);
		chk(out_pin, 8'hdb);
		tr <= 2'b10;
		dusp_host_inst.wr(OFS_PIN_FUNC, 8'hf0);
		cyc(2);
		chk(out_pin, 8'h7b);
		push(8'h77, 3'b000);
		cyc(2);
		chk(out_pin, 8'h6b);
		dusp_host_inst.rd(OFS_RX_DATA_A, d);
		// two clock sources high at a time, one per pin, each selection in turn
		for (int k = 0; k < 3; k++)
			for (int s = 1; s < 4; s++)
			begin
				src <= 6'(9 << k);
				dusp_host_inst.wr(OFS_PIN_FUNC, {4'h0, s[1:0], s[1:0]});
				cyc(5);
				chk({4'h0, out_pin[3:2], 2'b00}, (s - 1 == k) ? 8'h00 : 8'h0c);
			end
		dusp_host_inst.wr(OFS_AUX_IPC, 8'h81);
		cyc(1);
		chk({7'h0, baud_table_sel}, 8'h01);
		dusp_host_inst.wr(OFS_ISR_IMR, 8'h80);
		in_pin <= 4'b0010;
		cyc(6);
		chk({7'h0, irq}, 8'h00);
		rdm(OFS_AUX_IPC, 8'hff, 8'h22);
		in_pin <= 4'b0011;
		cyc(6);
		chk({7'h0, irq}, 8'h01);
		rdm(OFS_AUX_IPC, 8'hff, 8'h13);
		rdm(OFS_ISR_IMR, 8'h80, 8'h80);
		dusp_host_inst.wr(OFS_ISR_CLEAR, 8'h80);
		cyc(2);
		chk({7'h0, irq}, 8'h00);
		dusp_host_inst.wr(OFS_ISR_IMR, 8'h4c);
		for (int i = 0; i < 3; i++)
		begin
			@(posedge ref_clk);
			ev <= 3'(1 << i);
			@(posedge ref_clk);
			ev <= 3'b000;
			cyc(3);
			chk({7'h0, irq}, 8'h01);
			rdm(OFS_ISR_IMR, 8'hcc, ebit[i]);
			dusp_host_inst.wr(OFS_ISR_CLEAR, 8'hcc);
		end
		tr <= 2'b11;
		dusp_host_inst.wr(OFS_ISR_IMR, 8'h11);
		cyc(3);
		chk({7'h0, irq}, 8'h01);
		rdm(OFS_ISR_IMR, 8'h11, 8'h11);
		dusp_host_inst.wr(OFS_ISR_IMR, 8'h00);
		cyc(3);
		chk({7'h0, irq}, 8'h00);
		// an unmapped place reads as zero
		rdm(4'h0, 8'hff, 8'h00);
		conclude();
	end
endmodule : dusp_regs_tb_top
`default_nettype wire
